// ===== fws_ctrl.sv
// Host controller: Wishbone registers and status-polling sequencer for a NOR flash
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module fws_ctrl (
    input  wire logic                          I_CLK,
    input  wire logic                          I_RST,
    // Wishbone classic slave
    input  wire logic                          I_WB_CYC,
    input  wire logic                          I_WB_STB,
    input  wire logic                          I_WB_WE,
    input  wire logic [7:0]                    I_WB_ADR,
    input  wire logic [3:0]                    I_WB_SEL,
    input  wire logic [31:0]                   I_WB_DAT,
    output logic [31:0]                        O_WB_DAT,
    output logic                               O_WB_ACK,
    // Flash pins
    output logic [fws_pkg::ADDR_W-1:0]         O_FL_ADDR,
    output logic [fws_pkg::DATA_W-1:0]         O_FL_DQ,
    output logic                               O_FL_DQ_OE,
    input  wire logic [fws_pkg::DATA_W-1:0]    I_FL_DQ,
    output logic                               O_FL_CE_N,
    output logic                               O_FL_OE_N,
    output logic                               O_FL_WE_N,
    input  wire logic                          I_READY_BUSY_N_OUT
);

    //--------------------------------------------------------------
    // Sequencer states
    //--------------------------------------------------------------
    typedef enum logic [11:0] {
        S_IDLE  = 12'h001,
        S_WR    = 12'h002,   // Raw write
        S_RD    = 12'h004,   // Raw read
        S_PA    = 12'h008,   // Poll, first read
        S_PB    = 12'h010,   // Poll, second read
        S_PC    = 12'h020,   // Recheck after limit flag, first read
        S_PD    = 12'h040,   // Recheck, second read
        S_RST   = 12'h080,   // Write reset command
        S_XPRE  = 12'h100,   // Timer read before added sector
        S_XWR   = 12'h200,   // Added sector write
        S_XPOST = 12'h400,   // Timer read after added sector
        S_TC    = 12'h800    // Timer read after acceptance check
    } fws_seq_e;

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    fws_seq_e                      st_r, st_nxt;          // Sequencer state
    logic                          pend_r, pend_nxt;      // Cycle in flight
    logic [2:0]                    op_r, op_nxt;          // Running operation
    logic [fws_pkg::ADDR_W-1:0]    addr_r, addr_nxt;      // Operation address
    logic [fws_pkg::DATA_W-1:0]    wdat_r, wdat_nxt;      // Write word
    logic [fws_pkg::DATA_W-1:0]    rcmd_r, rcmd_nxt;      // Reset command word
    logic [fws_pkg::DATA_W-1:0]    first_r, first_nxt;    // First of a read pair
    logic [fws_pkg::DATA_W-1:0]    data_r, data_nxt;      // Last read word
    logic                          fail_r, fail_nxt;      // Operation failed
    logic                          nacc_r, nacc_nxt;      // Command not accepted
    logic                          tmr_r, tmr_nxt;        // Last erase timer value
    logic                          ack_r, ack_nxt;
    logic [31:0]                   rdat_r, rdat_nxt;
    logic                          rb_s1_r, rb_s2_r;      // Ready/busy synchroniser

    // Cycle engine hand-off
    logic                          cy_start;
    fws_pkg::fws_req_s             cy_req;
    logic                          cy_done;
    logic [fws_pkg::DATA_W-1:0]    cy_rdata;
    fws_pkg::fws_pins_s            pins;

    logic                          wb_take;               // Request taken this edge
    logic                          toggling;              // Toggle bit differs in pair
    logic [31:0]                   status;

    //--------------------------------------------------------------
    // Pin cycle engine
    //--------------------------------------------------------------
    fws_cycle u_cycle (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_start (cy_start),
        .i_req   (cy_req),
        .i_dq    (I_FL_DQ),
        .o_done  (cy_done),
        .o_rdata (cy_rdata),
        .o_pins  (pins)
    );

    // Ready/busy pin crosses in through two flops
    always_ff @(posedge I_CLK) begin
        rb_s1_r <= I_READY_BUSY_N_OUT;
        rb_s2_r <= rb_s1_r;
    end

    // Busy device pulls ready/busy low during program or erase
    assign status = {data_r, 11'h000, rb_s2_r, tmr_r, nacc_r, fail_r, (st_r != S_IDLE)};

    // Toggle compare on two successive reads
    assign toggling = first_r[fws_pkg::BIT_TOGGLE] ^ cy_rdata[fws_pkg::BIT_TOGGLE];

    assign wb_take = I_WB_CYC & I_WB_STB & ~ack_r;

    //--------------------------------------------------------------
    // Bus slave and sequencer next state
    //--------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        pend_nxt  = pend_r;
        op_nxt    = op_r;
        addr_nxt  = addr_r;
        wdat_nxt  = wdat_r;
        rcmd_nxt  = rcmd_r;
        first_nxt = first_r;
        data_nxt  = data_r;
        fail_nxt  = fail_r;
        nacc_nxt  = nacc_r;
        tmr_nxt   = tmr_r;
        ack_nxt   = wb_take;
        rdat_nxt  = rdat_r;
        cy_start  = 1'b0;
        cy_req    = '{we: 1'b0, addr: addr_r, data: wdat_r};

        // Register reads: answer one cycle after the request, unmapped reads zero
        if (wb_take && !I_WB_WE) begin
            case (I_WB_ADR)
                fws_pkg::REG_ADDR:   rdat_nxt = {12'h000, addr_r};
                fws_pkg::REG_WDATA:  rdat_nxt = {16'h0000, wdat_r};
                fws_pkg::REG_STATUS: rdat_nxt = status;
                fws_pkg::REG_RSTCMD: rdat_nxt = {16'h0000, rcmd_r};
                default:             rdat_nxt = 32'h0000_0000;
            endcase
        end

        // Register writes; ignored while an operation runs
        if (wb_take && I_WB_WE && st_r == S_IDLE) begin
            case (I_WB_ADR)
                fws_pkg::REG_ADDR: begin
                    if (I_WB_SEL[0]) addr_nxt[7:0]   = I_WB_DAT[7:0];
                    if (I_WB_SEL[1]) addr_nxt[15:8]  = I_WB_DAT[15:8];
                    if (I_WB_SEL[2]) addr_nxt[19:16] = I_WB_DAT[19:16];
                end
                fws_pkg::REG_WDATA: begin
                    if (I_WB_SEL[0]) wdat_nxt[7:0]  = I_WB_DAT[7:0];
                    if (I_WB_SEL[1]) wdat_nxt[15:8] = I_WB_DAT[15:8];
                end
                fws_pkg::REG_RSTCMD: begin
                    if (I_WB_SEL[0]) rcmd_nxt[7:0]  = I_WB_DAT[7:0];
                    if (I_WB_SEL[1]) rcmd_nxt[15:8] = I_WB_DAT[15:8];
                end
                fws_pkg::REG_CTRL: begin
                    if (I_WB_SEL[0]) begin
                        op_nxt   = I_WB_DAT[2:0];
                        fail_nxt = 1'b0;
                        nacc_nxt = 1'b0;
                        case (I_WB_DAT[2:0])
                            fws_pkg::OP_WRITE: st_nxt = S_WR;
                            fws_pkg::OP_READ:  st_nxt = S_RD;
                            fws_pkg::OP_POLL:  st_nxt = S_PA;
                            fws_pkg::OP_TCHK:  st_nxt = S_PA;
                            fws_pkg::OP_ADDS:  st_nxt = S_XPRE;
                            default:           st_nxt = S_IDLE;   // Unknown code starts nothing but still clears the flags
                        endcase
                    end
                end
                default: ;                                        // Unmapped write dropped
            endcase
        end

        // Each working state launches one cycle on entry, then waits for it
        if (st_r != S_IDLE && !pend_r) begin
            cy_start = 1'b1;
            pend_nxt = 1'b1;
        end
        if (st_r == S_WR || st_r == S_XWR) begin
            cy_req.we = 1'b1;
        end
        if (st_r == S_RST) begin
            cy_req.we   = 1'b1;
            cy_req.data = rcmd_r;
        end

        // Status reads all use the operation's own address
        if (cy_done) begin
            pend_nxt = 1'b0;
            data_nxt = cy_rdata;
            case (st_r)
                S_WR, S_RD, S_RST: st_nxt = S_IDLE;
                S_PA, S_PC: begin
                    first_nxt = cy_rdata;
                    st_nxt    = (st_r == S_PA) ? S_PB : S_PD;
                end
                S_PB: begin
                    if (op_r == fws_pkg::OP_TCHK) begin
                        // Still toggling means the erase sequence was taken
                        nacc_nxt = ~toggling;
                        st_nxt   = toggling ? S_TC : S_IDLE;
                    end else if (!toggling) begin
                        st_nxt = S_IDLE;                          // Finished cleanly
                    end else if (first_r[fws_pkg::BIT_LIMIT] | cy_rdata[fws_pkg::BIT_LIMIT]) begin
                        st_nxt = S_PC;
                    end else begin
                        st_nxt = S_PA;                            // Keep polling
                    end
                end
                S_PD: begin
                    // Toggle may stop just as the limit flag rises, so recheck
                    if (toggling) begin
                        fail_nxt = 1'b1;
                        st_nxt   = S_RST;
                    end else begin
                        st_nxt = S_IDLE;
                    end
                end
                S_XPRE: begin
                    // Timer always read first: command spacing is never assumed
                    tmr_nxt = cy_rdata[fws_pkg::BIT_TIMER];
                    // Window closed: the erase has begun and ignores new sectors
                    if (cy_rdata[fws_pkg::BIT_TIMER]) begin
                        nacc_nxt = 1'b1;
                        st_nxt   = S_IDLE;
                    end else begin
                        st_nxt = S_XWR;
                    end
                end
                S_XWR: st_nxt = S_XPOST;
                S_XPOST: begin
                    tmr_nxt  = cy_rdata[fws_pkg::BIT_TIMER];
                    nacc_nxt = cy_rdata[fws_pkg::BIT_TIMER];
                    st_nxt   = S_IDLE;
                end
                S_TC: begin
                    tmr_nxt = cy_rdata[fws_pkg::BIT_TIMER];
                    st_nxt  = S_IDLE;
                end
                default: st_nxt = S_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // State registers
    //--------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st_r    <= S_IDLE;
            pend_r  <= 1'b0;
            op_r    <= 3'h0;
            addr_r  <= '0;
            wdat_r  <= '0;
            rcmd_r  <= fws_pkg::RSTCMD_DEF;
            first_r <= '0;
            data_r  <= '0;
            fail_r  <= 1'b0;
            nacc_r  <= 1'b0;
            tmr_r   <= 1'b0;
            ack_r   <= 1'b0;
            rdat_r  <= 32'h0000_0000;
        end else begin
            st_r    <= st_nxt;
            pend_r  <= pend_nxt;
            op_r    <= op_nxt;
            addr_r  <= addr_nxt;
            wdat_r  <= wdat_nxt;
            rcmd_r  <= rcmd_nxt;
            first_r <= first_nxt;
            data_r  <= data_nxt;
            fail_r  <= fail_nxt;
            nacc_r  <= nacc_nxt;
            tmr_r   <= tmr_nxt;
            ack_r   <= ack_nxt;
            rdat_r  <= rdat_nxt;
        end
    end

    // Outputs come straight from flops here or in the cycle engine
    assign O_WB_DAT   = rdat_r;
    assign O_WB_ACK   = ack_r;
    assign O_FL_ADDR  = pins.addr;
    assign O_FL_DQ    = pins.dq;
    assign O_FL_DQ_OE = pins.dq_oe;
    assign O_FL_CE_N  = pins.ce_n;
    assign O_FL_OE_N  = pins.oe_n;
    assign O_FL_WE_N  = pins.we_n;

endmodule : fws_ctrl

// ===== fws_ctrl_properties.sv
// Checker on the flash strobes of the controller
`timescale 1ns/1ps
module fws_ctrl_properties (
    input wire logic                       I_CLK,
    input wire logic                       I_RST,
    input wire logic                       O_FL_CE_N,
    input wire logic                       O_FL_OE_N,
    input wire logic                       O_FL_WE_N,
    input wire logic                       O_FL_DQ_OE,
    input wire logic [fws_pkg::ADDR_W-1:0] O_FL_ADDR,
    input wire logic [fws_pkg::DATA_W-1:0] O_FL_DQ
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence rd_go; $fell(O_FL_OE_N); endsequence  // Read strobe starts
    sequence wr_go; $fell(O_FL_WE_N); endsequence  // Write strobe starts
    AST_ADDR_HOLD: assert property (!O_FL_OE_N && $past(!O_FL_OE_N) |-> $stable(O_FL_ADDR))
        else $error("address moved in read");
    AST_READ_LEN: assert property (rd_go |-> !O_FL_OE_N [*8] ##1 !O_FL_CE_N)
        else $error("read strobe short");
    AST_WRITE_HOLD: assert property (wr_go |-> (O_FL_DQ_OE && !O_FL_CE_N && $stable(O_FL_DQ)) [*8])
        else $error("write data not held");
    AST_NO_CLASH: assert property (!O_FL_OE_N |-> !O_FL_DQ_OE && O_FL_WE_N)
        else $error("bus driven in read");
    AST_RECOVERY: assert property ($rose(O_FL_CE_N) |=> O_FL_CE_N [*5])
        else $error("recovery too short");
endmodule : fws_ctrl_properties
bind fws_ctrl fws_ctrl_properties i_props (.I_CLK(I_CLK), .I_RST(I_RST), .O_FL_CE_N(O_FL_CE_N),
    .O_FL_OE_N(O_FL_OE_N), .O_FL_WE_N(O_FL_WE_N), .O_FL_DQ_OE(O_FL_DQ_OE), .O_FL_ADDR(O_FL_ADDR), .O_FL_DQ(O_FL_DQ));

// ===== fws_ctrl_tb_top.sv
// Self-checking bench for the flash status controller
`timescale 1ns/1ps
module fws_ctrl_tb_top;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lim = 1'b0, tmr = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] dat = 32'h0, rdat, st;
    logic [15:0] w, dq, dqo;
    logic [19:0] ad, fa;
    logic        ack, oe_n, we_n, rb_n;
    int          reads = 1, fail_count = 0, n_compared = 0, cycles = 0, seed = 32'hf0d6e9cf, nw;
    always #2.5 clk = ~clk;
    fws_ctrl i_fws_ctrl (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_SEL(4'hf), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_FL_ADDR(fa), .O_FL_DQ(dq), .O_FL_DQ_OE(),
        .I_FL_DQ(dqo), .O_FL_CE_N(), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n), .I_READY_BUSY_N_OUT(rb_n));
    fws_flash_model i_fws_flash_model (.i_oe_n(oe_n), .i_we_n(we_n), .i_lim(lim), .i_tmr(tmr), .i_dq(dq),
        .i_reads(reads), .o_dq(dqo), .o_rb_n(rb_n));
    // One classic bus cycle, held until the answer
    task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_en;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        st = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // Start an operation and poll until idle
    task automatic run(input logic [2:0] op);
        wb(1'b1, fws_pkg::REG_CTRL, {29'h0, op});
        do wb(1'b0, fws_pkg::REG_STATUS, 32'h0); while (st[fws_pkg::ST_BUSY] !== 1'b0);
    endtask : run
    function automatic logic [31:0] idle_st(input logic [15:0] d);
        return {d, 16'h0010};  // Ready, no flags
    endfunction : idle_st
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, fws_pkg::REG_STATUS, 32'h0);
        chk("status", idle_st(16'h0), st);
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h0, st);
        wb(1'b1, fws_pkg::REG_RSTCMD, 32'h00f0);
        repeat (3) begin  // Random programs, random busy length
            w = $random(seed) | 16'h0100;
            reads = 1 + ($random(seed) & 3);
            wb(1'b1, fws_pkg::REG_WDATA, {16'h0, w});
            ad = $random(seed);
            wb(1'b1, fws_pkg::REG_ADDR, {12'h0, ad});
            run(fws_pkg::OP_WRITE);
            run(fws_pkg::OP_POLL);
            chk("poll", idle_st(w), st & 32'hfffffff7);
            chk("flash address", {12'h0, ad}, {12'h0, fa});
        end
        lim = 1'b1;
        reads = 5;
        run(fws_pkg::OP_WRITE);
        run(fws_pkg::OP_POLL);
        chk("fail", 32'h12, st & 32'h17);
        chk("reset word", 32'h00f0, i_fws_flash_model.word);
        lim = 1'b0;
        reads = 200;
        run(fws_pkg::OP_WRITE);
        tmr = 1'b1;
        nw = i_fws_flash_model.n_wr;
        run(fws_pkg::OP_ADDS);
        chk("late sector", 32'h4, st & 32'h6);
        chk("writes", nw, i_fws_flash_model.n_wr);
        run(fws_pkg::OP_TCHK);
        chk("timer", 32'h8, st & 32'he);
        tmr = 1'b0;
        run(fws_pkg::OP_ADDS);
        chk("added sector", 32'h0, st & 32'he);
        chk("writes", nw + 1, i_fws_flash_model.n_wr);
        wb(1'b1, fws_pkg::REG_WDATA, 32'h00f0);
        run(fws_pkg::OP_WRITE);
        run(fws_pkg::OP_TCHK);
        chk("no toggle", 32'h4, st & 32'h6);
        conclude();
    end
endmodule : fws_ctrl_tb_top

// ===== fws_cycle.sv
// One asynchronous flash read or write cycle on the parallel pins
`timescale 1ns/1ps
module fws_cycle (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_start,  // One-cycle request
    input  wire fws_pkg::fws_req_s             i_req,
    input  wire logic [fws_pkg::DATA_W-1:0]    i_dq,     // Raw pin, other domain
    output logic                               o_done,   // One-cycle pulse
    output logic [fws_pkg::DATA_W-1:0]         o_rdata,
    output fws_pkg::fws_pins_s                 o_pins
);

    //--------------------------------------------------------------
    // State and registers
    //--------------------------------------------------------------
    typedef enum logic [4:0] {
        CY_IDLE   = 5'b00001,
        CY_SETUP  = 5'b00010,
        CY_STROBE = 5'b00100,
        CY_SAMPLE = 5'b01000,
        CY_REC    = 5'b10000
    } fws_cy_e;

    fws_cy_e                       st_r, st_nxt;        // Phase
    logic [fws_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;      // Phase counter
    fws_pkg::fws_req_s             req_r, req_nxt;      // Latched request
    fws_pkg::fws_pins_s            pins_r, pins_nxt;    // Pin drivers
    logic [fws_pkg::DATA_W-1:0]    rd_r, rd_nxt;        // Captured read word
    logic                          done_r, done_nxt;
    logic [fws_pkg::DATA_W-1:0]    dq_s1_r, dq_s2_r;    // Synchroniser

    // Data bus synchroniser; first stage feeds only the second
    always_ff @(posedge i_clk) begin
        dq_s1_r <= i_dq;
        dq_s2_r <= dq_s1_r;
    end

    // Next-state logic for the cycle phases
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        req_nxt  = req_r;
        pins_nxt = pins_r;
        rd_nxt   = rd_r;
        done_nxt = 1'b0;
        case (st_r)
            CY_IDLE: begin
                if (i_start) begin
                    req_nxt        = i_req;
                    pins_nxt.addr  = i_req.addr;
                    pins_nxt.dq    = i_req.data;
                    pins_nxt.dq_oe = i_req.we;  // Drive bus only on writes
                    pins_nxt.ce_n  = 1'b0;
                    cnt_nxt        = fws_pkg::CNT_W'(fws_pkg::T_SU_CYC - 1);
                    st_nxt         = CY_SETUP;
                end
            end
            CY_SETUP: begin
                if (cnt_r == '0) begin
                    pins_nxt.we_n = ~req_r.we;
                    pins_nxt.oe_n = req_r.we;
                    cnt_nxt       = fws_pkg::CNT_W'(fws_pkg::T_ACT_CYC - 1);
                    st_nxt        = CY_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            CY_STROBE: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else if (req_r.we) begin
                    // Rising write strobe latches the command word
                    pins_nxt.we_n = 1'b1;
                    pins_nxt.ce_n = 1'b1;
                    cnt_nxt       = fws_pkg::CNT_W'(fws_pkg::T_REC_CYC - 1);
                    st_nxt        = CY_REC;
                end else begin
                    // Keep OE low while valid data crosses the synchroniser
                    cnt_nxt = fws_pkg::CNT_W'(fws_pkg::SYNC_LAT - 1);
                    st_nxt  = CY_SAMPLE;
                end
            end
            CY_SAMPLE: begin
                if (cnt_r == '0) begin
                    rd_nxt        = dq_s2_r;
                    pins_nxt.oe_n = 1'b1;
                    pins_nxt.ce_n = 1'b1;
                    cnt_nxt       = fws_pkg::CNT_W'(fws_pkg::T_REC_CYC - 1);
                    st_nxt        = CY_REC;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            CY_REC: begin
                pins_nxt.dq_oe = 1'b0;
                if (cnt_r == '0) begin
                    done_nxt = 1'b1;
                    st_nxt   = CY_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: st_nxt = CY_IDLE;
        endcase
    end

    // Register all phase state; pins park idle after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r   <= CY_IDLE;
            cnt_r  <= '0;
            req_r  <= '0;
            pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, addr: '0, dq: '0};
            rd_r   <= '0;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            req_r  <= req_nxt;
            pins_r <= pins_nxt;
            rd_r   <= rd_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_done  = done_r;
    assign o_rdata = rd_r;
    assign o_pins  = pins_r;

endmodule : fws_cycle

// ===== fws_flash_model.sv
// Behavioural flash answering status reads
`timescale 1ns/1ps
module fws_flash_model (
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_lim,   // Next operation overruns
    input  wire logic        i_tmr,   // Erase window closed
    input  wire logic [15:0] i_dq,
    input  int               i_reads, // Busy reads per operation
    output logic      [15:0] o_dq,
    output logic             o_rb_n
);
    int          left = 0;      // Busy reads left
    int          n_wr = 0;      // Accepted writes
    logic        lim_r = 1'b0;
    logic        tog = 1'b0;
    logic [15:0] word = 16'h0;  // Array word
    logic [15:0] rd;
    // While busy, a closed window ignores all but the reset word
    always @(negedge i_we_n) if (left == 0 || !i_tmr || i_dq == 16'h00f0) begin
        n_wr++;
        word = i_dq;
        left = (i_dq == 16'h00f0) ? 0 : i_reads;
        lim_r = i_lim;
    end
    // Overrun keeps toggling until the reset word is written
    always @(negedge i_oe_n) if (left > 0) begin
        tog = !tog;
        if (!lim_r) left--;
    end
    assign rd = (left > 0) ? {9'h0, tog, lim_r, 1'b0, i_tmr, 3'h0} : word;
    // Released bus never shows the stale word
    assign o_dq = i_oe_n ? ~rd : rd;
    assign o_rb_n = (left == 0);
endmodule : fws_flash_model

// ===== fws_pkg.sv
// Shared constants and types for the flash write-status controller
//------------------------------------------------------------------
//------------------------------------------------------------------
package fws_pkg;

    //--------------------------------------------------------------
    // Clock and flash cycle timing
    //--------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;     // 200 MHz system clock
    localparam int T_ACT_NS      = 70;       // Strobe low time, covers access time
    localparam int T_REC_NS      = 30;       // Strobes high between cycles
    localparam int T_SU_NS       = 5;        // Address and data setup to strobe
    // Least times round up to whole cycles, never below one
    localparam int T_ACT_CYC = ((T_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                               ((T_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int T_REC_CYC = ((T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                               ((T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int T_SU_CYC  = ((T_SU_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                               ((T_SU_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int SYNC_LAT  = 2;            // Data bus synchroniser depth
    localparam int CNT_W     = 5;            // Phase counter width

    //--------------------------------------------------------------
    // Widths and status bit positions on the data bus
    //--------------------------------------------------------------
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int BIT_TIMER  = 3;           // erase_timer_flag
    localparam int BIT_LIMIT  = 5;           // timing_limit_flag
    localparam int BIT_TOGGLE = 6;           // first_toggle_bit

    //--------------------------------------------------------------
    // Register map, byte addresses on the bus
    //--------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;   // Write: start operation
    localparam logic [7:0] REG_ADDR   = 8'h04;   // Flash address of operation
    localparam logic [7:0] REG_WDATA  = 8'h08;   // Data word of a write
    localparam logic [7:0] REG_STATUS = 8'h0c;   // Flags and last read data
    localparam logic [7:0] REG_RSTCMD = 8'h10;   // Word written as reset command

    localparam logic [15:0] RSTCMD_DEF = 16'h0000;   // Plain default, set by software

    // Operation codes in CTRL[2:0]
    localparam logic [2:0] OP_WRITE = 3'h1;   // One raw write cycle
    localparam logic [2:0] OP_READ  = 3'h2;   // One read cycle
    localparam logic [2:0] OP_POLL  = 3'h3;   // Wait for program or erase end
    localparam logic [2:0] OP_ADDS  = 3'h4;   // Guarded added-sector write
    localparam logic [2:0] OP_TCHK  = 3'h5;   // Confirm acceptance, read timer

    // STATUS bit positions
    localparam int ST_BUSY   = 0;
    localparam int ST_FAIL   = 1;
    localparam int ST_NACC   = 2;
    localparam int ST_TIMER  = 3;
    localparam int ST_RDY    = 4;
    localparam int ST_DATA_L = 16;

    //--------------------------------------------------------------
    // Carriers
    //--------------------------------------------------------------
    typedef struct packed {
        logic              we;     // 1 write cycle, 0 read cycle
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fws_req_s;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              dq_oe;  // High while driving the data bus
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
    } fws_pins_s;

endpackage : fws_pkg
